// >>> hdl/gcv_regs.svh
// Register map, field positions, reset values and timing counts of the converter control
`ifndef GCV_REGS_SVH
`define GCV_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define GCV_ADDR_CTRL_PRI 8'h00
`define GCV_ADDR_CTRL_SEC 8'h04
`define GCV_ADDR_POS_TRIM 8'h08
`define GCV_ADDR_NEG_TRIM 8'h0C
`define GCV_ADDR_RESULT 8'h10

// ****************************************
// Primary control fields
// ****************************************
`define GCV_PRI_REG_EN 0
`define GCV_PRI_TRACK_EN 1
`define GCV_PRI_START 2
`define GCV_PRI_SE 3
`define GCV_PRI_CHOP 4
`define GCV_PRI_MUTE 5
`define GCV_PRI_SIGN 6
`define GCV_PRI_CHAN_LO 8
`define GCV_PRI_CHAN_HI 10

// ****************************************
// Secondary control fields
// ****************************************
`define GCV_SEC_ATTN 0
`define GCV_SEC_CLOAD 1
`define GCV_SEC_DLOAD 2
`define GCV_SEC_ATTN_EFF 3

// ****************************************
// Reset values and codes
// ****************************************
`define GCV_TRIM_RST 10'h200
`define GCV_SE_RST 1'h1
`define GCV_CHAN_BATTERY 3'h4
`define GCV_RESP_OKAY 2'h0
`define GCV_RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define GCV_CLK_PERIOD_PS 4000
`define GCV_CONV_TIME_PS 62500
`define GCV_CONV_CYCLES ((`GCV_CONV_TIME_PS + `GCV_CLK_PERIOD_PS - 1) / `GCV_CLK_PERIOD_PS)

`endif

// >>> hdl/gcv_pkg.sv
// Types shared by the converter control modules
package gcv_pkg;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'h0,
      SEQ_CONV1 = 2'h1,
      SEQ_CONV2 = 2'h3
   } gcv_seq_state_t;

   typedef struct packed
   {
      gcv_seq_state_t state;
      logic [7:0] cnt;
      logic chopRun;
      logic signApplied;
      logic convPhase;
      logic [9:0] firstCode;
      logic [9:0] result;
      logic done;
   } gcv_seq_t;

   typedef struct packed
   {
      logic regEn;
      logic trackEn;
      logic start;
      logic singleEnded;
      logic chop;
      logic mute;
      logic sign;
      logic [2:0] chan;
      logic attn;
      logic constLoad;
      logic dynLoad;
      logic [9:0] posTrim;
      logic [9:0] negTrim;
      logic [9:0] result;
      logic trackActive;
      logic attnEff;
      logic sampleLoad;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } gcv_top_t;

endpackage : gcv_pkg

// >>> hdl/gcv_conv_seq.sv
// Conversion phase sequencer with chopping and output sign handling
`include "gcv_regs.svh"

module gcv_conv_seq #(
   parameter int CONV_CYCLES = `GCV_CONV_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic startReq,
   input wire logic chopOn,
   input wire logic signIn,
   input wire logic [9:0] rawCode,
   // Status
   output logic convPhase,
   output logic signApplied,
   output logic done,
   output logic [9:0] result
);

   gcv_pkg::gcv_seq_t s_ff, nxt_s;
   logic [10:0] chopSum;
   logic [9:0] code;

   // Counter is eight bits wide, so longer conversions cannot be served
   if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
   begin : gen_bad_conv_cycles
      $error("CONV_CYCLES out of range");
   end

   // Sign turned back on the digital side
   function automatic logic [9:0] applySign(input logic [9:0] c, input logic inv);
      applySign = inv ? ~c : c;
   endfunction : applySign

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      code = applySign(rawCode, s_ff.signApplied); // R13
      chopSum = {1'b0, s_ff.firstCode} + {1'b0, code};
      unique case (s_ff.state)
         gcv_pkg::SEQ_IDLE:
         begin
            nxt_s.signApplied = signIn;
            if (startReq)
            begin
               nxt_s.state = gcv_pkg::SEQ_CONV1; // R6
               nxt_s.convPhase = 1'b1;
               nxt_s.cnt = 8'(CONV_CYCLES - 1);
               nxt_s.chopRun = chopOn;
            end
         end
         gcv_pkg::SEQ_CONV1:
         begin
            if (s_ff.cnt != 8'h00)
            begin
               nxt_s.cnt = s_ff.cnt - 8'h01; // R8
            end
            else if (s_ff.chopRun)
            begin
               // Second sample with opposite polarity cancels offset
               nxt_s.firstCode = code; // R11
               nxt_s.signApplied = ~s_ff.signApplied; // R11
               nxt_s.cnt = 8'(CONV_CYCLES - 1);
               nxt_s.state = gcv_pkg::SEQ_CONV2;
            end
            else
            begin
               nxt_s.result = code;
               nxt_s.done = 1'b1; // R7
               nxt_s.convPhase = 1'b0;
               nxt_s.signApplied = signIn;
               nxt_s.state = gcv_pkg::SEQ_IDLE;
            end
         end
         gcv_pkg::SEQ_CONV2:
         begin
            if (s_ff.cnt != 8'h00)
            begin
               nxt_s.cnt = s_ff.cnt - 8'h01;
            end
            else
            begin
               // Eleven-bit sum, lowest bit dropped for a ten-bit result
               nxt_s.result = chopSum[10:1]; // R11
               nxt_s.done = 1'b1;
               nxt_s.convPhase = 1'b0;
               nxt_s.signApplied = signIn;
               nxt_s.state = gcv_pkg::SEQ_IDLE;
            end
         end
         default:
         begin
            nxt_s.state = gcv_pkg::SEQ_IDLE;
            nxt_s.convPhase = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign convPhase = s_ff.convPhase;
   assign signApplied = s_ff.signApplied;
   assign done = s_ff.done;
   assign result = s_ff.result;

   // ****************************************
   // Checks
   // ****************************************
   logic [8:0] phaseCnt_ff;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !s_ff.convPhase)
      begin
         phaseCnt_ff <= 9'h000;
      end
      else
      begin
         phaseCnt_ff <= phaseCnt_ff + 9'h001;
      end
   end

   AST_CONV_LENGTH: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
      s_ff.done |-> phaseCnt_ff == 9'(s_ff.chopRun ? 2 * CONV_CYCLES : CONV_CYCLES))
      else $error("conversion length wrong");

   AST_CHOP_FLIP: assert property (@(posedge ref_clk) disable iff (sys_rst) // R11
      (s_ff.state == gcv_pkg::SEQ_CONV1 && nxt_s.state == gcv_pkg::SEQ_CONV2)
      |=> s_ff.signApplied != $past(s_ff.signApplied))
      else $error("chop second sample polarity not flipped");

   AST_SIGN_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
      (s_ff.state == gcv_pkg::SEQ_CONV1 && s_ff.cnt == 8'h00 && !s_ff.chopRun)
      |=> s_ff.done && s_ff.result == ($past(s_ff.signApplied) ? ~$past(rawCode)
      : $past(rawCode)))
      else $error("result sign handling wrong");

endmodule : gcv_conv_seq

// >>> hdl/gcv_top.sv
// Converter control block with its register slave
//
// Notes on behaviour
// R1: Mux selects four port inputs, battery, internals
// R2: Single-ended bit set, else input pairs differential
// R3: Attenuator bit triples the input scale
// R4: Software waits 20 us after regulator enable
// R5: Track input continuously while converter enabled
// R6: Writing start ends sampling, begins conversion
// R7: Conversion done clears start, resumes sampling
// R8: Conversion lasts about one 16 MHz cycle
// R9: Constant-load bit draws steady regulator load
// R10: Dynamic load drawn only while sampling
// R11: Chop takes two opposite-polarity samples
// R12: Mute switches input to center scale
// R13: Sign inverts converter input and output
// R14: Software sums chopped samples as 11 bits; here the sequencer adds them itself and keeps sum bits 10:1
// R15: Zero point 0.6 V, 1.8 V attenuated
// R16: Offset trims applied inside converter network
// R17: Calibration first measures positive offset muted
// R18: Calibration then measures negative, writes trims
// R19: Software keeps trim mean near 0x200
// R20: Software calibrates at init, verifies muted
// R21: Battery channel forces the attenuator on
// R22: Result latched as start bit clears
// R23: Start ignored while converter disabled
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "gcv_regs.svh"

module gcv_top #(
   parameter int CONV_CYCLES = `GCV_CONV_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register bus write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Register bus read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter macro controls
   output logic convRegulatorEnable,
   output logic convTrackEnable,
   output logic convPhase,
   output logic [2:0] channelSelect,
   output logic singleEndedSelect,
   output logic tripleScaleAttenuator,
   output logic constantLoadEnable,
   output logic samplingLoadEnable,
   output logic centerInputMute,
   output logic polarityInvert,
   output logic [9:0] positiveOffsetTrim,
   output logic [9:0] negativeOffsetTrim,
   // Converter macro code, same clock
   input wire logic [9:0] rawCode
);

   gcv_pkg::gcv_top_t r_ff, nxt_r;
   logic startPulse;
   logic seqConvPhase;
   logic seqSign;
   logic seqDone;
   logic [9:0] seqResult;
   logic doWrite;
   logic doRead;
   logic [31:0] wrWord;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
      input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            m[8*i +: 8] = data[8*i +: 8];
         end
      end
      mergeBytes = m;
   endfunction : mergeBytes

   function automatic logic addrKnown(input logic [7:0] a);
      addrKnown = (a == `GCV_ADDR_CTRL_PRI) || (a == `GCV_ADDR_CTRL_SEC)
         || (a == `GCV_ADDR_POS_TRIM) || (a == `GCV_ADDR_NEG_TRIM)
         || (a == `GCV_ADDR_RESULT);
   endfunction : addrKnown

   function automatic logic [31:0] readWord(input gcv_pkg::gcv_top_t r, input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         `GCV_ADDR_CTRL_PRI:
         begin
            d[`GCV_PRI_REG_EN] = r.regEn;
            d[`GCV_PRI_TRACK_EN] = r.trackEn;
            d[`GCV_PRI_START] = r.start;
            d[`GCV_PRI_SE] = r.singleEnded;
            d[`GCV_PRI_CHOP] = r.chop;
            d[`GCV_PRI_MUTE] = r.mute;
            d[`GCV_PRI_SIGN] = r.sign;
            d[`GCV_PRI_CHAN_HI:`GCV_PRI_CHAN_LO] = r.chan;
         end
         `GCV_ADDR_CTRL_SEC:
         begin
            d[`GCV_SEC_ATTN] = r.attn;
            d[`GCV_SEC_CLOAD] = r.constLoad;
            d[`GCV_SEC_DLOAD] = r.dynLoad;
            d[`GCV_SEC_ATTN_EFF] = r.attnEff;
         end
         `GCV_ADDR_POS_TRIM: d[9:0] = r.posTrim;
         `GCV_ADDR_NEG_TRIM: d[9:0] = r.negTrim;
         `GCV_ADDR_RESULT: d[9:0] = r.result;
         default: d = 32'h0000_0000;
      endcase
      readWord = d;
   endfunction : readWord

   // Refused while elaborating, before any clock runs
   if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
   begin : gen_bad_conv_cycles
      $error("CONV_CYCLES out of range");
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_r = r_ff;
      startPulse = 1'b0;
      doWrite = 1'b0;
      doRead = 1'b0;
      wrWord = 32'h0000_0000;

      // Address and data are taken independently, in either order
      if (s_axi_awvalid && r_ff.awReady)
      begin
         nxt_r.awHeld = 1'b1;
         nxt_r.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_ff.wReady)
      begin
         nxt_r.wHeld = 1'b1;
         nxt_r.wData = s_axi_wdata;
         nxt_r.wStrb = s_axi_wstrb;
      end
      if (r_ff.bValid && s_axi_bready)
      begin
         nxt_r.bValid = 1'b0;
      end

      // Write commits once both halves are held and no response waits
      if (r_ff.awHeld && r_ff.wHeld && !r_ff.bValid)
      begin
         doWrite = 1'b1;
         nxt_r.awHeld = 1'b0;
         nxt_r.wHeld = 1'b0;
         nxt_r.bValid = 1'b1;
         nxt_r.bResp = addrKnown(r_ff.awAddr) ? `GCV_RESP_OKAY : `GCV_RESP_SLVERR;
         wrWord = mergeBytes(readWord(r_ff, r_ff.awAddr), r_ff.wData, r_ff.wStrb);
         unique case (r_ff.awAddr)
            `GCV_ADDR_CTRL_PRI:
            begin
               nxt_r.regEn = wrWord[`GCV_PRI_REG_EN];
               nxt_r.trackEn = wrWord[`GCV_PRI_TRACK_EN];
               nxt_r.singleEnded = wrWord[`GCV_PRI_SE]; // R2
               nxt_r.chop = wrWord[`GCV_PRI_CHOP];
               nxt_r.mute = wrWord[`GCV_PRI_MUTE];
               nxt_r.sign = wrWord[`GCV_PRI_SIGN];
               nxt_r.chan = wrWord[`GCV_PRI_CHAN_HI:`GCV_PRI_CHAN_LO]; // R1
               // Start only accepted with tracking on and no conversion running
               if (wrWord[`GCV_PRI_START] && !r_ff.start
                  && wrWord[`GCV_PRI_TRACK_EN]) // R23
               begin
                  nxt_r.start = 1'b1; // R6
                  startPulse = 1'b1;
               end
            end
            `GCV_ADDR_CTRL_SEC:
            begin
               nxt_r.attn = wrWord[`GCV_SEC_ATTN];
               nxt_r.constLoad = wrWord[`GCV_SEC_CLOAD];
               nxt_r.dynLoad = wrWord[`GCV_SEC_DLOAD];
            end
            `GCV_ADDR_POS_TRIM: nxt_r.posTrim = wrWord[9:0];
            `GCV_ADDR_NEG_TRIM: nxt_r.negTrim = wrWord[9:0];
            default:
            begin
               // Result register and unmapped addresses take no data
            end
         endcase
      end

      // Read path: one outstanding read, answered one cycle after it is taken
      if (r_ff.rValid && s_axi_rready)
      begin
         nxt_r.rValid = 1'b0;
      end
      if (s_axi_arvalid && r_ff.arReady)
      begin
         doRead = 1'b1;
         nxt_r.rValid = 1'b1;
         nxt_r.rData = readWord(r_ff, s_axi_araddr);
         nxt_r.rResp = addrKnown(s_axi_araddr) ? `GCV_RESP_OKAY : `GCV_RESP_SLVERR;
      end

      // Finished conversion: result loads and start clears in the same cycle
      if (seqDone)
      begin
         nxt_r.start = 1'b0; // R7
         nxt_r.result = seqResult; // R22
      end

      // Disabling the converter drops a pending start as well
      if (!nxt_r.trackEn && !seqConvPhase)
      begin
         nxt_r.start = 1'b0;
      end

      nxt_r.awReady = !nxt_r.awHeld && !doWrite;
      nxt_r.wReady = !nxt_r.wHeld && !doWrite;
      nxt_r.arReady = !nxt_r.rValid && !doRead;

      // Sampling whenever enabled and not converting
      nxt_r.trackActive = nxt_r.trackEn && !nxt_r.start; // R5
      nxt_r.attnEff = nxt_r.attn || (nxt_r.chan == `GCV_CHAN_BATTERY); // R21
      nxt_r.sampleLoad = nxt_r.dynLoad && nxt_r.trackActive; // R10
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         r_ff <= '0;
         r_ff.singleEnded <= `GCV_SE_RST;
         r_ff.posTrim <= `GCV_TRIM_RST;
         r_ff.negTrim <= `GCV_TRIM_RST;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   gcv_conv_seq #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_seq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .startReq(startPulse),
      .chopOn(nxt_r.chop),
      .signIn(nxt_r.sign),
      .rawCode(rawCode),
      .convPhase(seqConvPhase),
      .signApplied(seqSign),
      .done(seqDone),
      .result(seqResult)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready = r_ff.awReady;
   assign s_axi_wready = r_ff.wReady;
   assign s_axi_bvalid = r_ff.bValid;
   assign s_axi_bresp = r_ff.bResp;
   assign s_axi_arready = r_ff.arReady;
   assign s_axi_rvalid = r_ff.rValid;
   assign s_axi_rdata = r_ff.rData;
   assign s_axi_rresp = r_ff.rResp;

   assign convRegulatorEnable = r_ff.regEn;
   assign convTrackEnable = r_ff.trackActive; // R5
   assign convPhase = seqConvPhase; // R6
   assign channelSelect = r_ff.chan; // R1
   assign singleEndedSelect = r_ff.singleEnded; // R2
   // Zero point follows scale: attenuated single-ended centre is three times higher
   assign tripleScaleAttenuator = r_ff.attnEff; // R3 R15
   assign constantLoadEnable = r_ff.constLoad; // R9
   assign samplingLoadEnable = r_ff.sampleLoad; // R10
   assign centerInputMute = r_ff.mute; // R12
   // Chopping flips the macro polarity for its second sample
   assign polarityInvert = seqSign; // R13
   assign positiveOffsetTrim = r_ff.posTrim; // R16
   assign negativeOffsetTrim = r_ff.negTrim; // R16

   // ****************************************
   // Checks
   // ****************************************
   sequence startSeen;
      $rose(r_ff.start);
   endsequence

   sequence clearSeen;
      $fell(r_ff.start);
   endsequence

   AST_START_NEEDS_TRACK: assert property (@(posedge ref_clk) disable iff (sys_rst) // R23
      startSeen |-> r_ff.trackEn)
      else $error("start accepted while disabled");

   AST_START_BEGINS_CONV: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
      startSeen |-> seqConvPhase && !r_ff.trackActive)
      else $error("start did not begin conversion");

   AST_START_SELF_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
      startSeen ##0 r_ff.trackEn |-> ##[1:520] clearSeen)
      else $error("start bit never cleared");

   AST_RESULT_ON_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst) // R22
      $past(seqDone) |-> !r_ff.start && r_ff.result == $past(seqResult))
      else $error("result not latched with start clear");

   AST_NO_TRACK_IN_CONV: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
      seqConvPhase |-> !r_ff.trackActive)
      else $error("tracking during conversion");

   AST_BATTERY_ATTN: assert property (@(posedge ref_clk) disable iff (sys_rst) // R21
      r_ff.chan == `GCV_CHAN_BATTERY |-> tripleScaleAttenuator)
      else $error("battery channel without attenuator");

   AST_SAMPLE_LOAD: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
      samplingLoadEnable |-> convTrackEnable && !seqConvPhase)
      else $error("dynamic load outside sampling");

   AST_MUTE_HOLDS: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
      (r_ff.mute && !(r_ff.awHeld && r_ff.wHeld)) |=> centerInputMute)
      else $error("mute dropped without write");

endmodule : gcv_top

// >>> testbench/gcv_macro_model.sv
// Converter macro stand-in that returns a code for the selected input
module gcv_macro_model
(
   // Controls from the block
   input wire logic centerInputMute,
   input wire logic polarityInvert,
   input wire logic [2:0] channelSelect,
   // Code back to the block
   output logic [9:0] rawCode
);
   timeunit 1ns;
   timeprecision 1ps;
   // Muted input at mid-scale plus a 3 LSB offset, same for either sign
   assign rawCode = centerInputMute ? 10'h203 :
      ({10{polarityInvert}} ^ {channelSelect, 7'h15});
endmodule : gcv_macro_model

// >>> testbench/test_adc_conversion_control.sv
// Self-checking bench for the converter control block
module test_adc_conversion_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV = 4;
   logic ref_clk, sys_rst, prevPhase;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic convRegulatorEnable, convTrackEnable, convPhase, singleEndedSelect;
   logic tripleScaleAttenuator, constantLoadEnable, samplingLoadEnable;
   logic centerInputMute, polarityInvert;
   logic [2:0] channelSelect;
   logic [9:0] positiveOffsetTrim, negativeOffsetTrim, rawCode;
   int bad_count, samples_checked, phaseLen;

   // ****
   // Instances
   // ****
   // Short conversion count keeps the run brief
   gcv_top #(.CONV_CYCLES(CONV)) dut (.*);
   gcv_macro_model partner (.*);

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      prevPhase <= convPhase;
      if (convPhase)
         phaseLen <= prevPhase ? phaseLen + 1 : 1;
   end

   // ****
   // Helpers
   // ****
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic timeUp();
      bad_count++;
      give_verdict();
   endtask : timeUp

   // Edge first, so no strobe is assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      s_axi_bready <= 1'b0;
      if (n >= 40)
         timeUp();
      chk("bresp", s_axi_bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      if (n >= 40)
         timeUp();
      chk("rresp", s_axi_rresp, er);
   endtask : rd

   task automatic conv(input logic [31:0] ctrl, input int len, input logic [9:0] exp);
      logic [31:0] d;
      int n;
      wr(8'h00, ctrl | 32'h6, 2'h0);
      chk("phaseOn", convPhase, 1'b1);
      chk("trackOff", convTrackEnable, 1'b0);
      chk("sLoadOff", samplingLoadEnable, 1'b0);
      n = 0;
      do
      begin
         rd(8'h00, d, 2'h0);
         n++;
      end while (d[2] !== 1'b0 && n < 40);
      if (n >= 40)
         timeUp();
      chk("phaseLen", phaseLen, len);
      chk("trackBack", convTrackEnable, 1'b1);
      rd(8'h10, d, 2'h0);
      chk("result", d, {22'h0, exp});
   endtask : conv

   // ****
   // Scenarios
   // ****
   task automatic testReset();
      logic [31:0] d;
      chk("seOut", singleEndedSelect, 1'b1);
      chk("posTrimOut", positiveOffsetTrim, 10'h200);
      rd(8'h00, d, 2'h0);
      chk("ctrlPri", d, 32'h8);
      rd(8'h0C, d, 2'h0);
      chk("negTrim", d, 32'h200);
      $display("reset test done");
   endtask : testReset

   task automatic testBus();
      logic [31:0] d;
      wr(8'h40, 32'hFF, 2'h2);
      rd(8'h40, d, 2'h2);
      chk("unmapped", d, 32'h0);
      wr(8'h10, 32'h155, 2'h0);
      rd(8'h10, d, 2'h0);
      chk("resultRo", d, 32'h0);
      $display("bus test done");
   endtask : testBus

   task automatic testRefused();
      logic [31:0] d;
      wr(8'h00, 32'h5, 2'h0);
      rd(8'h00, d, 2'h0);
      chk("startIgnored", d[2], 1'b0);
      chk("phaseIdle", convPhase, 1'b0);
      chk("regulator", convRegulatorEnable, 1'b1);
      // Settling time after the regulator comes on
      repeat (5000) @(posedge ref_clk);
      $display("refusal test done");
   endtask : testRefused

   task automatic testCalibrate();
      wr(8'h04, 32'h6, 2'h0);
      chk("cLoad", constantLoadEnable, 1'b1);
      wr(8'h08, 32'h200, 2'h0);
      wr(8'h0C, 32'h200, 2'h0);
      conv(32'h2B, CONV, 10'h203);
      chk("sLoadOn", samplingLoadEnable, 1'b1);
      chk("muteOut", centerInputMute, 1'b1);
      conv(32'h6B, CONV, 10'h1FC);
      chk("polOut", polarityInvert, 1'b1);
      wr(8'h08, 32'h1FA, 2'h0);
      wr(8'h0C, 32'h208, 2'h0);
      chk("posTrim", positiveOffsetTrim, 10'h1FA);
      chk("negTrim", negativeOffsetTrim, 10'h208);
      // Muted result should sit near mid-scale once trimmed
      conv(32'h2B, CONV, 10'h203);
      $display("calibration test done");
   endtask : testCalibrate

   task automatic testChop();
      conv(32'h3B, 2 * CONV, 10'h1FF);
      $display("chop test done");
   endtask : testChop

   task automatic testChannels();
      logic [31:0] d;
      for (int ch = 0; ch < 5; ch++)
      begin
         conv(32'h43 | (ch[0] << 3) | (ch << 8), CONV, {ch[2:0], 7'h15});
         chk("chan", channelSelect, ch[2:0]);
         chk("se", singleEndedSelect, ch[0]);
         chk("attnBat", tripleScaleAttenuator, ch == 4);
      end
      wr(8'h00, 32'h3, 2'h0);
      chk("attnOff", tripleScaleAttenuator, 1'b0);
      wr(8'h04, 32'h7, 2'h0);
      chk("attnOn", tripleScaleAttenuator, 1'b1);
      rd(8'h04, d, 2'h0);
      chk("ctrlSec", d, 32'hF);
      $display("channel test done");
   endtask : testChannels

   initial
   begin
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      testReset();
      testBus();
      testRefused();
      testCalibrate();
      testChop();
      testChannels();
      give_verdict();
   end
endmodule : test_adc_conversion_control
